// ==== mpuac_regs.svh ====
// What this block does
// - bit 12 of region access control: 1 forbids instruction fetch from the region
// - bits 10:8 are the data permission code for privileged and user accesses
// - code 000 denies every data access and raises a permission fault
// - code 001 allows privileged read/write, denies all user access
// - code 010 allows privileged read/write, user read; user write faults
// - code 011 is full access; code 110 is read-only for both levels
// - code 101 allows privileged reads only, denies all user access
// - bits 5:3 extend the memory type together with bits 1 and 0
// - bit 2 marks shareable, effective for normal memory only
// - fetches need read permission and execute-never clear
// - region access control and region select only reachable when privileged
// - region select bits 3:0 pick which region's registers are accessed
// - data memory base in bits 31:12, reset zero
// - data memory size code in bits 5:2, 0000 none, 0011..1000 4KB..128KB
// - data memory enable in bit 0, reset zero
// - without data memory built, enable ignores writes and reads zero
// - instruction memory register reports base and size, may boot enabled
// - instruction base resets to FFFF0 with boot enable and high vector, else 0
// - instruction enable comes up set when boot enable is high at reset
`ifndef MPUAC_REGS_SVH
`define MPUAC_REGS_SVH
// coprocessor coordinate {crn, crm, op2}
`define MPUAC_SEL_RAC 11'h030C
`define MPUAC_SEL_RGN 11'h0310
`define MPUAC_SEL_DTCM 11'h0488
`define MPUAC_SEL_ITCM 11'h0489
`define MPUAC_NUM_REGIONS 16
`define MPUAC_RAC_EXEC_NEVER 12
`define MPUAC_RAC_PERM 10:8
`define MPUAC_RAC_TYPE_EXT 5:3
`define MPUAC_RAC_S 2
`define MPUAC_RAC_C 1
`define MPUAC_RAC_B 0
`define MPUAC_RGN_FIELD 3:0
`define MPUAC_TCM_BASE 31:12
`define MPUAC_TCM_SIZE 5:2
`define MPUAC_TCM_EN 0
`define MPUAC_RAC_RST 10'h000
`define MPUAC_RGN_RST 4'h0
`define MPUAC_BASE_RST 20'h0_0000
`define MPUAC_BASE_HIVEC 20'hF_FFF0
`define MPUAC_DTCM_BUILT 1'b1
`define MPUAC_DTCM_SIZE 4'h5
`define MPUAC_ITCM_SIZE 4'h5
`define MPUAC_PERM_NONE 3'h0
`define MPUAC_PERM_PRIV 3'h1
`define MPUAC_PERM_UREAD 3'h2
`define MPUAC_PERM_FULL 3'h3
`define MPUAC_PERM_PRO 3'h5
`define MPUAC_PERM_RO 3'h6
`endif

// ==== mpuac_pkg.sv ====
package mpuac_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } mpuac_cp_req_type;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } mpuac_cp_rsp_type;
  typedef struct packed {
    logic valid;
    logic priv;
    logic write;
    logic fetch;
    logic [3:0] region;
  } mpuac_chk_req_type;
  typedef enum logic [1:0] {
    MPUAC_STRONG = 2'h0,
    MPUAC_DEVICE = 2'h1,
    MPUAC_NORMAL = 2'h2
  } mpuac_class_type;
  typedef struct packed {
    logic done;
    logic fault;
    logic shareable;
    mpuac_class_type mem_class;
  } mpuac_chk_rsp_type;
  typedef struct packed {
    logic exec_never;
    logic [2:0] data_perm_field;
    logic [2:0] memory_type_ext;
    logic s;
    logic c;
    logic b;
  } mpuac_rac_type;
  typedef enum logic [1:0] {
    MPUAC_INIT_WAIT = 2'h0,
    MPUAC_INIT_SYNC = 2'h1,
    MPUAC_INIT_LOAD = 2'h3,
    MPUAC_INIT_DONE = 2'h2
  } mpuac_init_type;
endpackage

// ==== mpuac_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mpuac_regs.svh"
module mpuac_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic boot_imem_enable_p0,
  input wire logic high_vector_boot_p0,
  input wire mpuac_pkg::mpuac_cp_req_type cp_req,
  output mpuac_pkg::mpuac_cp_rsp_type cp_rsp,
  input wire mpuac_pkg::mpuac_chk_req_type chk_req,
  output mpuac_pkg::mpuac_chk_rsp_type chk_rsp,
  output logic [19:0] dtcm_base,
  output logic dtcm_enable,
  output logic [19:0] itcm_base,
  output logic itcm_enable
);
  // ************************************************************
  // reset and strap synchronisers
  // ************************************************************
  logic rst_q1;
  logic rst_n;
  logic boot_q1;
  logic boot_q2;
  logic hivec_q1;
  logic hivec_q2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q1 <= 1'b0;
      boot_q2 <= 1'b0;
      hivec_q1 <= 1'b0;
      hivec_q2 <= 1'b0;
    end else begin
      boot_q1 <= boot_imem_enable_p0;
      boot_q2 <= boot_q1;
      hivec_q1 <= high_vector_boot_p0;
      hivec_q2 <= hivec_q1;
    end
  end

  // ************************************************************
  // strap capture after reset release
  // ************************************************************
  // straps need two edges to cross the synchroniser before they are loaded
  mpuac_pkg::mpuac_init_type init_state;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_state <= mpuac_pkg::MPUAC_INIT_WAIT;
    end else begin
      unique case (init_state)
        mpuac_pkg::MPUAC_INIT_WAIT: init_state <= mpuac_pkg::MPUAC_INIT_SYNC;
        mpuac_pkg::MPUAC_INIT_SYNC: init_state <= mpuac_pkg::MPUAC_INIT_LOAD;
        mpuac_pkg::MPUAC_INIT_LOAD: init_state <= mpuac_pkg::MPUAC_INIT_DONE;
        mpuac_pkg::MPUAC_INIT_DONE: init_state <= mpuac_pkg::MPUAC_INIT_DONE;
      endcase
    end
  end

  logic init_load;
  assign init_load = (init_state == mpuac_pkg::MPUAC_INIT_LOAD);

  // ************************************************************
  // coprocessor access decode
  // ************************************************************
  logic [10:0] sel;
  logic hit_rac;
  logic hit_rgn;
  logic hit_dtcm;
  logic hit_itcm;
  logic acc_ok;
  logic wr_en;

  assign sel = {cp_req.crn, cp_req.crm, cp_req.op2};
  assign hit_rac = (sel == `MPUAC_SEL_RAC);
  assign hit_rgn = (sel == `MPUAC_SEL_RGN);
  assign hit_dtcm = (sel == `MPUAC_SEL_DTCM);
  assign hit_itcm = (sel == `MPUAC_SEL_ITCM);
  // user mode and unknown coordinates are refused with no side effect
  assign acc_ok = cp_req.valid && cp_req.priv &&
                  (hit_rac || hit_rgn || hit_dtcm || hit_itcm);
  assign wr_en = acc_ok && cp_req.write;

  // ************************************************************
  // region select and per-region attributes
  // ************************************************************
  logic [3:0] region_select;
  mpuac_pkg::mpuac_rac_type region_access_control [`MPUAC_NUM_REGIONS];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      region_select <= `MPUAC_RGN_RST;
    end else if (wr_en && hit_rgn) begin
      region_select <= cp_req.wdata[`MPUAC_RGN_FIELD];
    end
  end

  // all sixteen indices are implemented, so no select value is out of range
  genvar gi;
  generate
    for (gi = 0; gi < `MPUAC_NUM_REGIONS; gi++) begin : g_region
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          region_access_control[gi] <= `MPUAC_RAC_RST;
        end else if (wr_en && hit_rac && region_select == 4'(gi)) begin
          region_access_control[gi] <= {cp_req.wdata[`MPUAC_RAC_EXEC_NEVER],
                                        cp_req.wdata[`MPUAC_RAC_PERM],
                                        cp_req.wdata[`MPUAC_RAC_TYPE_EXT],
                                        cp_req.wdata[`MPUAC_RAC_S],
                                        cp_req.wdata[`MPUAC_RAC_C],
                                        cp_req.wdata[`MPUAC_RAC_B]};
        end
      end
    end
  endgenerate

  // ************************************************************
  // tightly coupled memory region registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dtcm_base <= `MPUAC_BASE_RST;
      dtcm_enable <= 1'b0;
    end else if (wr_en && hit_dtcm) begin
      dtcm_base <= cp_req.wdata[`MPUAC_TCM_BASE];
      dtcm_enable <= cp_req.wdata[`MPUAC_TCM_EN] & `MPUAC_DTCM_BUILT;
    end
  end

  // a software write landing on the load cycle is lost to the strap value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      itcm_base <= `MPUAC_BASE_RST;
      itcm_enable <= 1'b0;
    end else if (init_load) begin
      itcm_base <= (boot_q2 && hivec_q2) ? `MPUAC_BASE_HIVEC : `MPUAC_BASE_RST;
      itcm_enable <= boot_q2;
    end else if (wr_en && hit_itcm) begin
      itcm_base <= cp_req.wdata[`MPUAC_TCM_BASE];
      itcm_enable <= cp_req.wdata[`MPUAC_TCM_EN];
    end
  end

  // ************************************************************
  // register read path
  // ************************************************************
  mpuac_pkg::mpuac_rac_type cur_rac;
  logic [31:0] next_rdata;
  assign cur_rac = region_access_control[region_select];

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc_ok && !cp_req.write) begin
      if (hit_rac) begin
        next_rdata[`MPUAC_RAC_EXEC_NEVER] = cur_rac.exec_never;
        next_rdata[`MPUAC_RAC_PERM] = cur_rac.data_perm_field;
        next_rdata[`MPUAC_RAC_TYPE_EXT] = cur_rac.memory_type_ext;
        next_rdata[`MPUAC_RAC_S] = cur_rac.s;
        next_rdata[`MPUAC_RAC_C] = cur_rac.c;
        next_rdata[`MPUAC_RAC_B] = cur_rac.b;
      end else if (hit_rgn) begin
        next_rdata[`MPUAC_RGN_FIELD] = region_select;
      end else if (hit_dtcm) begin
        next_rdata[`MPUAC_TCM_BASE] = dtcm_base;
        next_rdata[`MPUAC_TCM_SIZE] = `MPUAC_DTCM_SIZE;
        next_rdata[`MPUAC_TCM_EN] = dtcm_enable;
      end else begin
        next_rdata[`MPUAC_TCM_BASE] = itcm_base;
        next_rdata[`MPUAC_TCM_SIZE] = `MPUAC_ITCM_SIZE;
        next_rdata[`MPUAC_TCM_EN] = itcm_enable;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_rsp <= '0;
    end else begin
      cp_rsp.ack <= cp_req.valid;
      cp_rsp.err <= cp_req.valid && !acc_ok;
      cp_rsp.rdata <= next_rdata;
    end
  end

  // ************************************************************
  // permission and attribute check
  // ************************************************************
  mpuac_pkg::mpuac_rac_type chk_rac;
  logic [3:0] perm;
  logic rd_ok;
  logic wr_ok;
  logic next_fault;
  mpuac_pkg::mpuac_class_type next_class;
  assign chk_rac = region_access_control[chk_req.region];

  // perm = {priv read, priv write, user read, user write}
  always_comb begin
    unique case (chk_rac.data_perm_field)
      `MPUAC_PERM_NONE: perm = 4'h0;
      `MPUAC_PERM_PRIV: perm = 4'hC;
      `MPUAC_PERM_UREAD: perm = 4'hE;
      `MPUAC_PERM_FULL: perm = 4'hF;
      `MPUAC_PERM_PRO: perm = 4'h8;
      `MPUAC_PERM_RO: perm = 4'hA;
      default: perm = 4'h0;
    endcase
  end

  assign rd_ok = chk_req.priv ? perm[3] : perm[1];
  assign wr_ok = chk_req.priv ? perm[2] : perm[0];

  always_comb begin
    if (chk_req.fetch) begin
      next_fault = !(rd_ok && !chk_rac.exec_never);
    end else if (chk_req.write) begin
      next_fault = !wr_ok;
    end else begin
      next_fault = !rd_ok;
    end
  end

  // type extension with C and B; reserved combinations fall into normal
  always_comb begin
    if (chk_rac.memory_type_ext == 3'h0 && !chk_rac.c && !chk_rac.b) begin
      next_class = mpuac_pkg::MPUAC_STRONG;
    end else if (!chk_rac.c && ((chk_rac.memory_type_ext == 3'h0 && chk_rac.b) ||
                 (chk_rac.memory_type_ext == 3'h2 && !chk_rac.b))) begin
      next_class = mpuac_pkg::MPUAC_DEVICE;
    end else begin
      next_class = mpuac_pkg::MPUAC_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_rsp <= '0;
    end else begin
      chk_rsp.done <= chk_req.valid;
      chk_rsp.fault <= chk_req.valid && next_fault;
      chk_rsp.shareable <= chk_rac.s && (next_class == mpuac_pkg::MPUAC_NORMAL);
      chk_rsp.mem_class <= next_class;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_perm_none;
    chk_req.valid && chk_rac.data_perm_field == 3'h0 |=> chk_rsp.done && chk_rsp.fault;
  endproperty
  a_perm_none: assert property (p_perm_none) else $error("code 000 did not fault");

  property p_perm_priv;
    chk_req.valid && !chk_req.fetch && chk_rac.data_perm_field == 3'h1
      |=> chk_rsp.fault == !$past(chk_req.priv);
  endproperty
  a_perm_priv: assert property (p_perm_priv) else $error("code 001 wrong");

  property p_perm_uwrite;
    chk_req.valid && !chk_req.fetch && !chk_req.priv &&
      chk_rac.data_perm_field == 3'h2 |=> chk_rsp.fault == $past(chk_req.write);
  endproperty
  a_perm_uwrite: assert property (p_perm_uwrite) else $error("code 010 wrong");

  property p_perm_full;
    chk_req.valid && !chk_req.fetch && chk_rac.data_perm_field == 3'h3 |=> !chk_rsp.fault;
  endproperty
  a_perm_full: assert property (p_perm_full) else $error("code 011 faulted");

  property p_perm_pro;
    chk_req.valid && !chk_req.fetch && chk_rac.data_perm_field == 3'h5
      |=> chk_rsp.fault == ($past(chk_req.write) || !$past(chk_req.priv));
  endproperty
  a_perm_pro: assert property (p_perm_pro) else $error("code 101 wrong");

  property p_xn;
    chk_req.valid && chk_req.fetch && chk_rac.exec_never |=> chk_rsp.fault;
  endproperty
  a_xn: assert property (p_xn) else $error("fetch from execute-never region");

  property p_user_cp;
    cp_req.valid && !cp_req.priv ##1 cp_rsp.ack |-> cp_rsp.err && cp_rsp.rdata == 32'h0000_0000;
  endproperty
  a_user_cp: assert property (p_user_cp) else $error("user access not refused");

  property p_rgn;
    wr_en && hit_rgn |=> region_select == $past(cp_req.wdata[3:0]) ##1 1'b1;
  endproperty
  a_rgn: assert property (p_rgn) else $error("region select not loaded");

  property p_share;
    chk_rsp.mem_class != mpuac_pkg::MPUAC_NORMAL |-> !chk_rsp.shareable;
  endproperty
  a_share: assert property (p_share) else $error("shareable on non-normal");

  property p_dtcm_absent;
    wr_en && hit_dtcm |=> dtcm_enable == ($past(cp_req.wdata[0]) && `MPUAC_DTCM_BUILT);
  endproperty
  a_dtcm_absent: assert property (p_dtcm_absent) else $error("absent tcm enabled");

  property p_boot;
    init_load |=> itcm_enable == $past(boot_q2) &&
      itcm_base == (($past(boot_q2) && $past(hivec_q2)) ? 20'hF_FFF0 : 20'h0_0000);
  endproperty
  a_boot: assert property (p_boot) else $error("boot strap load wrong");

  c_fault: cover property (chk_req.valid ##1 chk_rsp.fault);
  c_fetch_ok: cover property (chk_req.valid && chk_req.fetch ##1 !chk_rsp.fault);
  c_rac_write: cover property (wr_en && hit_rac);
  c_boot: cover property (init_load && boot_q2 && hivec_q2);
endmodule
`default_nettype wire

// ==== mpuac_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module mpuac_core_model (
  output mpuac_pkg::mpuac_cp_req_type cp_req,
  input wire logic clk,
  input wire mpuac_pkg::mpuac_cp_rsp_type cp_rsp
);
  initial begin
    cp_req = '0;
  end
  // the select field is only 4 bits wide, so every value stays below the 16 regions
  // valid is a one-cycle pulse; released lines carry inverted data so stale values never match
  task automatic xfer(input logic w, input logic p, input logic [10:0] co,
                      input logic [31:0] d, output mpuac_pkg::mpuac_cp_rsp_type r);
    @(posedge clk);
    cp_req <= '{1'b1, w, p, co[10:7], co[6:3], co[2:0], d};
    @(posedge clk);
    cp_req <= '{1'b0, ~w, ~p, ~co[10:7], ~co[6:3], ~co[2:0], ~d};
    @(negedge clk);
    r = cp_rsp;
  endtask
endmodule
`default_nettype wire

// ==== test_mpuac_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "mpuac_regs.svh"
module test_mpuac_core;
  logic clk;
  logic arst_n;
  logic boot_p0;
  logic hivec_p0;
  mpuac_pkg::mpuac_cp_req_type cp_req;
  mpuac_pkg::mpuac_cp_rsp_type cp_rsp;
  mpuac_pkg::mpuac_chk_req_type chk_req;
  mpuac_pkg::mpuac_chk_rsp_type chk_rsp;
  logic [19:0] dtcm_base;
  logic dtcm_enable;
  logic [19:0] itcm_base;
  logic itcm_enable;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  integer seed = 22;
  mpuac_pkg::mpuac_cp_rsp_type r;
  mpuac_pkg::mpuac_chk_rsp_type c;
  logic [31:0] d;
  logic [31:0] attr [16];
  logic [19:0] eb;
  logic [3:0] rg;

  mpuac_core u_mpuac_core (
    .clk(clk), .arst_n(arst_n), .boot_imem_enable_p0(boot_p0),
    .high_vector_boot_p0(hivec_p0), .cp_req(cp_req), .cp_rsp(cp_rsp),
    .chk_req(chk_req), .chk_rsp(chk_rsp), .dtcm_base(dtcm_base),
    .dtcm_enable(dtcm_enable), .itcm_base(itcm_base), .itcm_enable(itcm_enable)
  );
  mpuac_core_model u_mpuac_core_model (.cp_req(cp_req), .clk(clk), .cp_rsp(cp_rsp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************
  // checking and expectations
  // ****************************************
  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_flag(input string what, input logic e, input logic g);
    check_word(what, {31'h0, e}, {31'h0, g});
  endtask

  function automatic logic exp_fault(input logic [2:0] pc, input logic nx, input logic p,
                                     input logic w, input logic f);
    logic rd;
    logic wr;
    case (pc)
      3'h1: begin rd = p; wr = p; end
      3'h2: begin rd = 1'b1; wr = p; end
      3'h3: begin rd = 1'b1; wr = 1'b1; end
      3'h5: begin rd = p; wr = 1'b0; end
      3'h6: begin rd = 1'b1; wr = 1'b0; end
      default: begin rd = 1'b0; wr = 1'b0; end
    endcase
    if (f) return !rd || nx;
    return w ? !wr : !rd;
  endfunction

  function automatic logic [1:0] exp_class(input logic [31:0] a);
    if (a[5:3] == 3'h0 && a[1:0] == 2'h0) return 2'h0;
    if ((a[5:3] == 3'h0 && a[1:0] == 2'h1) || (a[5:3] == 3'h2 && a[1:0] == 2'h0)) return 2'h1;
    return 2'h2;
  endfunction

  function automatic logic [31:0] tcm_word(input logic [19:0] b, input logic en);
    return {b, 6'h00, `MPUAC_ITCM_SIZE, 1'b0, en};
  endfunction

  task automatic chk(input logic p, input logic w, input logic f, input logic [3:0] rn);
    @(posedge clk);
    chk_req <= '{1'b1, p, w, f, rn};
    @(posedge clk);
    chk_req <= '{1'b0, ~p, ~w, ~f, ~rn};
    @(negedge clk);
    c = chk_rsp;
  endtask

  task automatic do_reset(input logic boot, input logic hv);
    @(posedge clk);
    arst_n <= 1'b0;
    boot_p0 <= boot;
    hivec_p0 <= hv;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // straps land on the fifth edge after release; look once they have settled
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      $display("[FAIL] timeout expected done seen hang");
      test_done();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n = 1'b0;
    boot_p0 = 1'b0;
    hivec_p0 = 1'b0;
    chk_req = '0;
    for (int s = 0; s < 4; s++) begin
      do_reset(s[0], s[1]);
      eb = (s == 3) ? 20'hF_FFF0 : 20'h0_0000;
      check_word("itcm_base", {12'h000, eb}, {12'h000, itcm_base});
      check_flag("itcm_enable", s[0], itcm_enable);
      check_flag("dtcm_enable", 1'b0, dtcm_enable);
      u_mpuac_core_model.xfer(1'b0, 1'b1, `MPUAC_SEL_ITCM, 32'h0000_0000, r);
      check_word("itcm read", tcm_word(eb, s[0]), r.rdata);
      check_flag("ack", 1'b1, r.ack);
      u_mpuac_core_model.xfer(1'b0, 1'b1, `MPUAC_SEL_DTCM, 32'h0000_0000, r);
      check_word("dtcm read", 32'h0000_0014, r.rdata);
    end
    for (int i = 0; i < 16; i++) begin
      attr[i] = $random(seed);
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_RGN, 32'hFFFF_FFF0 | i, r);
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_RAC, attr[i], r);
      check_flag("attr write err", 1'b0, r.err);
    end
    for (int i = 15; i >= 0; i--) begin
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_RGN, i, r);
      u_mpuac_core_model.xfer(1'b0, 1'b1, `MPUAC_SEL_RAC, 32'h0000_0000, r);
      check_word("attr read", attr[i] & 32'h0000_173F, r.rdata);
    end
    u_mpuac_core_model.xfer(1'b1, 1'b0, `MPUAC_SEL_RGN, 32'h0000_0005, r);
    check_word("user write", 32'h0000_0001, {r.rdata[30:0], r.err});
    u_mpuac_core_model.xfer(1'b0, 1'b0, `MPUAC_SEL_RAC, 32'h0000_0000, r);
    check_word("user read", 32'h0000_0001, {r.rdata[30:0], r.err});
    u_mpuac_core_model.xfer(1'b0, 1'b1, `MPUAC_SEL_RGN, 32'h0000_0000, r);
    check_word("select kept", 32'h0000_0000, r.rdata);
    u_mpuac_core_model.xfer(1'b0, 1'b1, 11'h000, 32'h0000_0000, r);
    check_flag("unknown err", 1'b1, r.err);
    for (int k = 0; k < 16; k++) begin
      rg = $random(seed);
      d = $random(seed);
      d[12] = k[0];
      d[10:8] = k[3:1];
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_RGN, {28'h000_0000, rg}, r);
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_RAC, d, r);
      for (int m = 0; m < 6; m++) begin
        chk(m[0], m[1], m[2], rg);
        check_flag("done", 1'b1, c.done);
        check_flag("fault", exp_fault(d[10:8], d[12], m[0], m[1], m[2]), c.fault);
        check_word("class", {30'h0, exp_class(d)}, {30'h0, c.mem_class});
        check_flag("shareable", d[2] && exp_class(d) == 2'h2, c.shareable);
      end
    end
    for (int k = 0; k < 4; k++) begin
      d = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_DTCM, d, r);
      u_mpuac_core_model.xfer(1'b0, 1'b1, `MPUAC_SEL_DTCM, 32'h0000_0000, r);
      check_word("dtcm read", {d[31:12], 6'h00, `MPUAC_DTCM_SIZE, 1'b0, d[0]}, r.rdata);
      check_word("dtcm port", {11'h000, d[31:12], d[0]}, {11'h000, dtcm_base, dtcm_enable});
      u_mpuac_core_model.xfer(1'b1, 1'b1, `MPUAC_SEL_ITCM, ~d, r);
      u_mpuac_core_model.xfer(1'b0, 1'b1, `MPUAC_SEL_ITCM, 32'h0000_0000, r);
      check_word("itcm read", tcm_word(~d[31:12], ~d[0]), r.rdata);
      check_word("itcm port", {11'h000, ~d[31:12], ~d[0]}, {11'h000, itcm_base, itcm_enable});
    end
    test_done();
  end
endmodule
`default_nettype wire
